/* servo_ctrl_pkg.sv */
// Shared constants and types for the servo control object dictionary.
package servo_ctrl_pkg;
	// ****************************************
	// Dictionary indices
	// ****************************************
	localparam logic [15:0] IDX_CONTROL_WORD = 16'h6040;
	localparam logic [15:0] IDX_STATUS_WORD = 16'h6041;
	localparam logic [15:0] IDX_MODE_SELECT = 16'h6060;
	localparam logic [15:0] IDX_MODE_READBACK = 16'h6061;
	localparam logic [15:0] IDX_MEASURED_SPEED = 16'h606c;
	localparam logic [15:0] IDX_SPEED_REACH_THR = 16'h606d;
	localparam logic [15:0] IDX_SPEED_REACH_WIN = 16'h606e;
	localparam logic [15:0] IDX_ZERO_SPEED_THR = 16'h606f;
	localparam logic [15:0] IDX_ZERO_SPEED_WIN = 16'h6070;
	localparam logic [15:0] IDX_TARGET_TORQUE = 16'h6071;
	localparam logic [15:0] IDX_TORQUE_REFERENCE = 16'h6074;
	localparam logic [15:0] IDX_REF_POLARITY = 16'h607e;
	localparam logic [15:0] IDX_SPEED_CEILING = 16'h607f;
	localparam logic [15:0] IDX_ACCEL_RATE = 16'h6083;
	localparam logic [15:0] IDX_DECEL_RATE = 16'h6084;
	localparam logic [15:0] IDX_TORQUE_SLOPE = 16'h6087;
	localparam logic [15:0] IDX_TARGET_SPEED = 16'h60ff;
	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [15:0] RST_CONTROL_WORD = 16'h0000;
	localparam logic [7:0] RST_MODE = 8'h00;
	localparam logic [15:0] RST_SPEED_REACH_THR = 16'h000a;
	localparam logic [15:0] RST_SPEED_REACH_WIN = 16'h0000;
	localparam logic [15:0] RST_ZERO_SPEED_THR = 16'h000a;
	localparam logic [15:0] RST_ZERO_SPEED_WIN = 16'h0000;
	localparam logic [7:0] RST_REF_POLARITY = 8'h00;
	localparam logic [31:0] RST_SPEED_CEILING = 32'h06400000;
	localparam logic [31:0] RST_ACCEL_RATE = 32'h682aaaab;
	localparam logic [31:0] RST_DECEL_RATE = 32'h682aaaab;
	localparam logic [31:0] RST_TARGET_SPEED = 32'h00000000;
	localparam logic [15:0] RST_TARGET_TORQUE = 16'h0000;
	localparam logic [31:0] RST_TORQUE_SLOPE = 32'hffffffff;
	// ****************************************
	// Mode codes and control word values
	// ****************************************
	localparam logic [7:0] MODE_PROFILE_VELOCITY = 8'h03;
	localparam logic [7:0] MODE_PROFILE_TORQUE = 8'h04;
	localparam logic [15:0] CW_START = 16'h0000;
	localparam logic [15:0] CW_SHUTDOWN = 16'h0006;
	localparam logic [15:0] CW_SWITCH_ON = 16'h0007;
	localparam logic [15:0] CW_ENABLE = 16'h000f;
	localparam logic [15:0] CW_FAULT_RESET = 16'h0080;
	// Control word bit positions
	localparam int CW_SWITCH_ON_BIT = 0;
	localparam int CW_VOLTAGE_BIT = 1;
	localparam int CW_QSTOP_BIT = 2;
	localparam int CW_OP_ENABLE_BIT = 3;
	localparam int CW_RESET_BIT = 7;
	localparam int CW_HALT_BIT = 8;
	// Status word bit positions
	localparam int SW_READY_BIT = 0;
	localparam int SW_SWITCHED_ON_BIT = 1;
	localparam int SW_ENABLED_BIT = 2;
	localparam int SW_FAULT_BIT = 3;
	localparam int SW_VOLTAGE_BIT = 4;
	localparam int SW_QSTOP_BIT = 5;
	localparam int SW_DISABLED_BIT = 6;
	localparam int SW_ALARM_BIT = 7;
	localparam int SW_REMOTE_BIT = 9;
	localparam int SW_REACHED_BIT = 10;
	localparam int SW_LIMIT_BIT = 11;
	// ****************************************
	// Types
	// ****************************************
	// Drive enable state machine
	typedef enum logic [2:0] {
		ST_SWITCH_ON_DISABLED = 3'b000,
		ST_READY = 3'b001,
		ST_SWITCHED_ON = 3'b010,
		ST_ENABLED = 3'b011,
		ST_QUICK_STOP = 3'b100,
		ST_FAULT = 3'b101
	} drive_state_t;
	// Host user commands
	typedef enum logic [2:0] {
		CMD_WRITE = 3'b000,
		CMD_READ = 3'b001,
		CMD_ENABLE = 3'b010,
		CMD_CLEAR_ALARM = 3'b011,
		CMD_TORQUE_MODE = 3'b100,
		CMD_VELOCITY_MODE = 3'b101
	} host_cmd_t;
	// Host sequencer states
	typedef enum logic [1:0] {
		HS_IDLE = 2'b00,
		HS_ISSUE = 2'b01,
		HS_WAIT = 2'b10
	} host_state_t;
endpackage : servo_ctrl_pkg

/* servo_od_if.sv */
// Object dictionary access link between host controller and drive.
`timescale 1ns/1ns
interface servo_od_if;
	logic req; // Host access request, one cycle
	logic we; // Write when high, read when low
	logic [15:0] index; // Dictionary index
	logic [31:0] wdata; // Write data, low bits used
	logic ack; // Drive answer pulse
	logic [31:0] rdata; // Read data, valid with ack
	logic miss; // Unmapped index, valid with ack
	modport drive (input req, we, index, wdata, output ack, rdata, miss);
	modport host (output req, we, index, wdata, input ack, rdata, miss);
endinterface : servo_od_if

/* servo_velocity_torque_ctrl.sv */
// Drive end: object dictionary, enable state machine and torque ramp.
`timescale 1ns/1ns
// What this block does
// - Mode 4 runs torque control from target
// - Mode 3 runs speed control from target
// - Host enables with start, 6, 7, 15
// - Rising edge of 128 clears clearable alarm
// - Enabled only while bits 0,1,3 set
// - Control bit 2 low forces quick stop from enabled
// - One fault reset per bit 7 rise
// - Bit 7 high ignores other control bits
// - Bit 8 halts motion, clear resumes
// - Unused control bits have no effect
// - Status enabled and ready bits track state
// - Status bit 6 while enable impossible
// - Status bit 3 shows drive fault
// - Status bit 7 shows alarm
// - Status bit 9 once control word accepted
// - Status bit 10 when torque target reached
// - Status bit 11 shows position limit
// - Torque reference ramps at slope rate
module servo_velocity_torque_ctrl import servo_ctrl_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	servo_od_if.drive od,
	input wire logic fault_event,
	input wire logic alarm_event,
	input wire logic alarm_clearable,
	input wire logic sw_limit_hit,
	input wire logic [31:0] measured_speed_in,
	output logic drive_enabled,
	output logic velocity_run,
	output logic torque_run,
	output logic [31:0] speed_command,
	output logic [15:0] torque_reference,
	output logic [15:0] status_word
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [15:0] control_word;
		logic [7:0] operation_mode_select;
		logic [7:0] operation_mode_readback;
		logic [15:0] speed_reach_threshold;
		logic [15:0] speed_reach_window;
		logic [15:0] zero_speed_threshold;
		logic [15:0] zero_speed_window;
		logic [7:0] reference_polarity;
		logic [31:0] speed_ceiling;
		logic [31:0] profile_accel_rate;
		logic [31:0] profile_decel_rate;
		logic [31:0] target_speed;
		logic [15:0] target_torque;
		logic [31:0] torque_slope;
		logic [15:0] torque_ref;
		logic [31:0] speed_cmd;
		drive_state_t state;
		logic fault;
		logic alarm;
		logic remote;
		logic reset_bit_prev;
		logic ack;
		logic miss;
		logic [31:0] rdata;
		logic [15:0] status;
	} drive_regs_t;

	drive_regs_t cur; // Registered state
	drive_regs_t next_cur; // Next state
	logic [3:0] cw; // Enable-relevant control bits
	logic reset_rise; // Fault reset edge this cycle
	logic halt; // Halt request
	logic in_torque; // Torque mode selected
	logic running; // Enabled and not halted
	logic signed [15:0] goal; // Torque the ramp heads for
	logic signed [16:0] diff; // Goal minus present reference
	logic [16:0] mag; // Magnitude of diff
	logic [16:0] step; // Ramp step this cycle
	logic [15:0] stat; // Status word being built
	logic [31:0] rd; // Read mux

	// ****************************************
	// Next state
	// ****************************************
	// All decisions in one process; the register update below only copies
	always_comb begin
		next_cur = cur;
		cw = cur.control_word[3:0];
		// Halt is a control reference too, so a held reset bit masks it
		halt = cur.control_word[CW_HALT_BIT] && !cur.control_word[CW_RESET_BIT];
		reset_rise = cur.control_word[CW_RESET_BIT] & ~cur.reset_bit_prev;
		next_cur.reset_bit_prev = cur.control_word[CW_RESET_BIT];
		in_torque = (cur.operation_mode_readback == MODE_PROFILE_TORQUE);
		running = (cur.state == ST_ENABLED) && !halt;

		// Enable sequence; frozen while the reset bit is held
		if (cur.control_word[CW_RESET_BIT]) begin
			// Other control references inactive during reset
			next_cur.state = cur.state;
		end else begin
			case (cur.state)
				ST_SWITCH_ON_DISABLED: begin
					if (cw[2:0] == CW_SHUTDOWN[2:0]) begin
						next_cur.state = ST_READY;
					end
				end
				ST_READY: begin
					if (!cw[CW_VOLTAGE_BIT] || !cw[CW_QSTOP_BIT]) begin
						next_cur.state = ST_SWITCH_ON_DISABLED;
					end else if (cw[CW_SWITCH_ON_BIT]) begin
						next_cur.state = ST_SWITCHED_ON;
					end
				end
				ST_SWITCHED_ON: begin
					if (!cw[CW_VOLTAGE_BIT] || !cw[CW_QSTOP_BIT]) begin
						next_cur.state = ST_SWITCH_ON_DISABLED;
					end else if (!cw[CW_SWITCH_ON_BIT]) begin
						next_cur.state = ST_READY;
					end else if (cw[CW_OP_ENABLE_BIT]) begin
						next_cur.state = ST_ENABLED;
					end
				end
				ST_ENABLED: begin
					if (!cw[CW_VOLTAGE_BIT]) begin
						next_cur.state = ST_SWITCH_ON_DISABLED;
					end else if (!cw[CW_QSTOP_BIT]) begin
						next_cur.state = ST_QUICK_STOP;
					end else if (!cw[CW_SWITCH_ON_BIT]) begin
						next_cur.state = ST_READY;
					end else if (!cw[CW_OP_ENABLE_BIT]) begin
						next_cur.state = ST_SWITCHED_ON;
					end
				end
				ST_QUICK_STOP: begin
					// Leave once the torque reference has ramped out
					if (cur.torque_ref == 16'h0000) begin
						next_cur.state = ST_SWITCH_ON_DISABLED;
					end
				end
				ST_FAULT: begin
					next_cur.state = ST_FAULT;
				end
				default: begin
					next_cur.state = ST_SWITCH_ON_DISABLED;
				end
			endcase
		end

		// Fault reset edge clears a clearable alarm; new events win over it
		if (reset_rise && alarm_clearable) begin
			next_cur.fault = 1'b0;
			next_cur.alarm = 1'b0;
			if (cur.state == ST_FAULT) begin
				next_cur.state = ST_SWITCH_ON_DISABLED;
			end
		end
		if (alarm_event) begin
			next_cur.alarm = 1'b1;
		end
		if (fault_event) begin
			next_cur.fault = 1'b1;
			next_cur.alarm = 1'b1;
			next_cur.state = ST_FAULT;
		end

		// Torque ramp: head for target while running in torque mode, else for zero
		goal = (running && in_torque) ? $signed(cur.target_torque) : 16'sh0000;
		diff = {goal[15], goal} - {cur.torque_ref[15], cur.torque_ref};
		mag = diff[16] ? 17'(-diff) : 17'(diff);
		step = (cur.torque_slope > {15'h0000, mag}) ? mag : cur.torque_slope[16:0];
		if (diff[16]) begin
			next_cur.torque_ref = 16'(cur.torque_ref - step[15:0]);
		end else begin
			next_cur.torque_ref = 16'(cur.torque_ref + step[15:0]);
		end

		// Speed command follows target only in velocity mode, unhalted
		if (running && cur.operation_mode_readback == MODE_PROFILE_VELOCITY) begin
			next_cur.speed_cmd = cur.target_speed;
		end else begin
			next_cur.speed_cmd = 32'h00000000;
		end

		// Status word
		stat = 16'h0000;
		stat[SW_READY_BIT] = (cur.state == ST_READY) || (cur.state == ST_SWITCHED_ON)
			|| (cur.state == ST_ENABLED);
		stat[SW_SWITCHED_ON_BIT] = stat[SW_READY_BIT];
		stat[SW_VOLTAGE_BIT] = stat[SW_READY_BIT];
		stat[SW_ENABLED_BIT] = (cur.state == ST_ENABLED);
		stat[SW_FAULT_BIT] = cur.fault;
		stat[SW_QSTOP_BIT] = (cur.state != ST_QUICK_STOP);
		stat[SW_DISABLED_BIT] = (cur.state == ST_SWITCH_ON_DISABLED)
			|| (cur.state == ST_FAULT);
		stat[SW_ALARM_BIT] = cur.alarm;
		stat[SW_REMOTE_BIT] = cur.remote;
		stat[SW_REACHED_BIT] = in_torque && (cur.torque_ref == cur.target_torque)
			&& (cur.state == ST_ENABLED);
		stat[SW_LIMIT_BIT] = sw_limit_hit;
		next_cur.status = stat;

		// Dictionary read mux; narrow objects sit in the low bits
		case (od.index)
			IDX_CONTROL_WORD: rd = {16'h0000, cur.control_word};
			IDX_STATUS_WORD: rd = {16'h0000, cur.status};
			IDX_MODE_SELECT: rd = {24'h000000, cur.operation_mode_select};
			IDX_MODE_READBACK: rd = {24'h000000, cur.operation_mode_readback};
			IDX_MEASURED_SPEED: rd = measured_speed_in;
			IDX_SPEED_REACH_THR: rd = {16'h0000, cur.speed_reach_threshold};
			IDX_SPEED_REACH_WIN: rd = {16'h0000, cur.speed_reach_window};
			IDX_ZERO_SPEED_THR: rd = {16'h0000, cur.zero_speed_threshold};
			IDX_ZERO_SPEED_WIN: rd = {16'h0000, cur.zero_speed_window};
			IDX_TARGET_TORQUE: rd = {16'h0000, cur.target_torque};
			IDX_TORQUE_REFERENCE: rd = {16'h0000, cur.torque_ref};
			IDX_REF_POLARITY: rd = {24'h000000, cur.reference_polarity};
			IDX_SPEED_CEILING: rd = cur.speed_ceiling;
			IDX_ACCEL_RATE: rd = cur.profile_accel_rate;
			IDX_DECEL_RATE: rd = cur.profile_decel_rate;
			IDX_TORQUE_SLOPE: rd = cur.torque_slope;
			IDX_TARGET_SPEED: rd = cur.target_speed;
			default: rd = 32'hffffffff;
		endcase

		// Access answer, one cycle after the request
		next_cur.ack = od.req;
		next_cur.miss = od.req && (rd == 32'hffffffff) && (od.index != IDX_ACCEL_RATE)
			&& (od.index != IDX_DECEL_RATE) && (od.index != IDX_TORQUE_SLOPE)
			&& (od.index != IDX_SPEED_CEILING) && (od.index != IDX_TARGET_SPEED)
			&& (od.index != IDX_MEASURED_SPEED);
		next_cur.rdata = (od.req && !od.we) ? (next_cur.miss ? 32'h00000000 : rd) : cur.rdata;

		// Writes; read-only indices are taken but change nothing
		if (od.req && od.we) begin
			case (od.index)
				IDX_CONTROL_WORD: begin
					next_cur.control_word = od.wdata[15:0];
					next_cur.remote = 1'b1;
				end
				IDX_MODE_SELECT: begin
					next_cur.operation_mode_select = od.wdata[7:0];
				end
				IDX_SPEED_REACH_THR: next_cur.speed_reach_threshold = od.wdata[15:0];
				IDX_SPEED_REACH_WIN: next_cur.speed_reach_window = od.wdata[15:0];
				IDX_ZERO_SPEED_THR: next_cur.zero_speed_threshold = od.wdata[15:0];
				IDX_ZERO_SPEED_WIN: next_cur.zero_speed_window = od.wdata[15:0];
				IDX_TARGET_TORQUE: next_cur.target_torque = od.wdata[15:0];
				IDX_REF_POLARITY: next_cur.reference_polarity = od.wdata[7:0];
				IDX_SPEED_CEILING: next_cur.speed_ceiling = od.wdata;
				IDX_ACCEL_RATE: next_cur.profile_accel_rate = od.wdata;
				IDX_DECEL_RATE: next_cur.profile_decel_rate = od.wdata;
				IDX_TORQUE_SLOPE: next_cur.torque_slope = od.wdata;
				IDX_TARGET_SPEED: next_cur.target_speed = od.wdata;
				default: begin
				end
			endcase
		end
		// Selected mode takes effect one cycle after it is written
		next_cur.operation_mode_readback = cur.operation_mode_select;
	end

	// ****************************************
	// Register update
	// ****************************************
	// Synchronous reset; clock enable freezes everything
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cur <= '0;
			cur.control_word <= RST_CONTROL_WORD;
			cur.operation_mode_select <= RST_MODE;
			cur.operation_mode_readback <= RST_MODE;
			cur.speed_reach_threshold <= RST_SPEED_REACH_THR;
			cur.speed_reach_window <= RST_SPEED_REACH_WIN;
			cur.zero_speed_threshold <= RST_ZERO_SPEED_THR;
			cur.zero_speed_window <= RST_ZERO_SPEED_WIN;
			cur.reference_polarity <= RST_REF_POLARITY;
			cur.speed_ceiling <= RST_SPEED_CEILING;
			cur.profile_accel_rate <= RST_ACCEL_RATE;
			cur.profile_decel_rate <= RST_DECEL_RATE;
			cur.target_speed <= RST_TARGET_SPEED;
			cur.target_torque <= RST_TARGET_TORQUE;
			cur.torque_slope <= RST_TORQUE_SLOPE;
			cur.state <= ST_SWITCH_ON_DISABLED;
			cur.status <= 16'h0060;
		end else if (ce) begin
			cur <= next_cur;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign od.ack = cur.ack && ce;
	assign od.rdata = cur.rdata;
	assign od.miss = cur.miss;
	assign drive_enabled = cur.status[SW_ENABLED_BIT];
	assign velocity_run = (cur.speed_cmd != 32'h00000000);
	assign torque_run = (cur.operation_mode_readback == MODE_PROFILE_TORQUE)
		&& (cur.state == ST_ENABLED);
	assign speed_command = cur.speed_cmd;
	assign torque_reference = cur.torque_ref;
	assign status_word = cur.status;
endmodule : servo_velocity_torque_ctrl

/* servo_host_seq.sv */
// Host end: turns user commands into dictionary access sequences.
`timescale 1ns/1ns
module servo_host_seq import servo_ctrl_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	servo_od_if.host od,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [2:0] cmd_kind,
	input wire logic [15:0] cmd_index,
	input wire logic [31:0] cmd_data,
	output logic resp_valid,
	output logic [31:0] resp_data,
	output logic resp_miss
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		host_state_t state;
		host_cmd_t kind;
		logic [1:0] step;
		logic [15:0] index;
		logic [31:0] data;
		logic req;
		logic we;
		logic [15:0] od_index;
		logic [31:0] od_wdata;
		logic resp;
		logic [31:0] rdata;
		logic miss;
	} host_regs_t;

	host_regs_t cur; // Registered state
	host_regs_t next_cur; // Next state
	logic [1:0] last_step; // Final step of the command

	// ****************************************
	// Sequencer
	// ****************************************
	// One access at a time; waits for the answer before the next
	always_comb begin
		next_cur = cur;
		next_cur.req = 1'b0;
		next_cur.resp = 1'b0;
		case (cur.kind)
			CMD_ENABLE: last_step = 2'h3;
			CMD_CLEAR_ALARM: last_step = 2'h1;
			default: last_step = 2'h0;
		endcase
		case (cur.state)
			HS_IDLE: begin
				if (cmd_valid) begin
					next_cur.kind = host_cmd_t'(cmd_kind);
					next_cur.index = cmd_index;
					next_cur.data = cmd_data;
					next_cur.step = 2'h0;
					next_cur.state = HS_ISSUE;
				end
			end
			HS_ISSUE: begin
				next_cur.req = 1'b1;
				next_cur.we = (cur.kind != CMD_READ);
				next_cur.od_index = IDX_CONTROL_WORD;
				next_cur.od_wdata = 32'h00000000;
				case (cur.kind)
					CMD_WRITE, CMD_READ: begin
						next_cur.od_index = cur.index;
						next_cur.od_wdata = cur.data;
					end
					CMD_ENABLE: begin
						// Start value, then 6, 7 and 15
						case (cur.step)
							2'h0: next_cur.od_wdata = {16'h0000, CW_START};
							2'h1: next_cur.od_wdata = {16'h0000, CW_SHUTDOWN};
							2'h2: next_cur.od_wdata = {16'h0000, CW_SWITCH_ON};
							default: next_cur.od_wdata = {16'h0000, CW_ENABLE};
						endcase
					end
					CMD_CLEAR_ALARM: begin
						// A zero first guarantees a rising edge on the reset bit
						if (cur.step == 2'h0) begin
							next_cur.od_wdata = {16'h0000, CW_START};
						end else begin
							next_cur.od_wdata = {16'h0000, CW_FAULT_RESET};
						end
					end
					CMD_TORQUE_MODE: begin
						next_cur.od_index = IDX_MODE_SELECT;
						next_cur.od_wdata = {24'h000000, MODE_PROFILE_TORQUE};
					end
					default: begin
						next_cur.od_index = IDX_MODE_SELECT;
						next_cur.od_wdata = {24'h000000, MODE_PROFILE_VELOCITY};
					end
				endcase
				next_cur.state = HS_WAIT;
			end
			HS_WAIT: begin
				if (od.ack) begin
					if (cur.step == last_step) begin
						next_cur.resp = 1'b1;
						next_cur.rdata = od.rdata;
						next_cur.miss = od.miss;
						next_cur.state = HS_IDLE;
					end else begin
						next_cur.step = 2'(cur.step + 2'h1);
						next_cur.state = HS_ISSUE;
					end
				end
			end
			default: begin
				next_cur.state = HS_IDLE;
			end
		endcase
	end

	// ****************************************
	// Register update
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cur <= '0;
			cur.state <= HS_IDLE;
			cur.kind <= CMD_WRITE;
		end else if (ce) begin
			cur <= next_cur;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign cmd_ready = (cur.state == HS_IDLE);
	assign od.req = cur.req && ce;
	assign od.we = cur.we;
	assign od.index = cur.od_index;
	assign od.wdata = cur.od_wdata;
	assign resp_valid = cur.resp && ce;
	assign resp_data = cur.rdata;
	assign resp_miss = cur.miss;
endmodule : servo_host_seq

/* servo_vt_asserts.sv */
// Checker for the dictionary link between host sequencer and drive.
`timescale 1ns/1ns
module servo_vt_asserts import servo_ctrl_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic req,
	input wire logic we,
	input wire logic [15:0] index,
	input wire logic [31:0] wdata,
	input wire logic ack,
	input wire logic [31:0] rdata,
	input wire logic miss
);
	// ****************************************
	// Shadow of host writes
	// ****************************************
	logic [7:0] mode; // Last mode select written
	logic [15:0] cw; // Last control word written
	logic rd; // Read request
	logic known; // Index is in the dictionary
	assign rd = req && !we;
	assign known = index inside {16'h6040, 16'h6041, 16'h6060, 16'h6061, [16'h606c:16'h6071],
		16'h6074, 16'h607e, 16'h607f, 16'h6083, 16'h6084, 16'h6087, 16'h60ff};
	// Shadows follow writes so read-backs can be judged without the drive
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mode <= 8'h00;
			cw <= 16'h0000;
		end else if (req && we && index == IDX_MODE_SELECT) begin
			mode <= wdata[7:0];
		end else if (req && we && index == IDX_CONTROL_WORD) begin
			cw <= wdata[15:0];
		end
	end
	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	property p_ack; req |=> ack; endproperty
	a_ack: assert property (p_ack) else $error("no answer after request");
	property p_stray; ack |-> $past(req); endproperty
	a_stray: assert property (p_stray) else $error("answer without request");
	property p_one; req |=> !req; endproperty
	a_one: assert property (p_one) else $error("request before answer");
	property p_hit; req && known |=> !miss; endproperty
	a_hit: assert property (p_hit) else $error("mapped index missed");
	property p_miss; req && !known |=> miss && rdata == 32'h0; endproperty
	a_miss: assert property (p_miss) else $error("unmapped index answered");
	property p_mode; rd && index == IDX_MODE_READBACK |=> rdata == {24'h0, mode}; endproperty
	a_mode: assert property (p_mode) else $error("mode readback wrong");
	property p_stat; rd && index == IDX_STATUS_WORD |=> rdata[31:16] == 16'h0; endproperty
	a_stat: assert property (p_stat) else $error("status upper bits set");
	property p_cw; rd && index == IDX_CONTROL_WORD |=> rdata == {16'h0, cw}; endproperty
	a_cw: assert property (p_cw) else $error("control word readback wrong");
	c_cw: cover property (req && we && index == IDX_CONTROL_WORD);
	c_miss: cover property (ack && miss);
	c_mode: cover property (rd && index == IDX_MODE_READBACK);
endmodule : servo_vt_asserts

/* test_servo_velocity_torque_ctrl.sv */
// Self-checking bench: host sequencer and drive joined by the link.
`timescale 1ns/1ns
module test_servo_velocity_torque_ctrl import servo_ctrl_pkg::*;;
	logic ref_clk = 0, rst = 1, ce = 1, fault_event = 0, alarm_event = 0, alarm_clearable = 0;
	logic sw_limit_hit = 0, cmd_valid = 0, cmd_ready, resp_valid, resp_miss;
	logic drive_enabled, velocity_run, torque_run;
	logic [2:0] cmd_kind = 0;
	logic [15:0] cmd_index = 0, torque_reference, status_word;
	logic [31:0] cmd_data = 0, measured_speed_in = 32'h12345678, got, resp_data, speed_command;
	int bad_count = 0, total_checks = 0;
	// Reset values read back over the link
	logic [15:0] ri [8] = '{16'h6041, 16'h6061, 16'h606d, 16'h606f, 16'h607f, 16'h6083,
		16'h6084, 16'h60ff};
	logic [31:0] rv [8] = '{32'h60, 0, 32'ha, 32'ha, 32'h6400000, 32'h682aaaab,
		32'h682aaaab, 0};
	always #5 ref_clk = ~ref_clk;
	servo_od_if link ();
	servo_velocity_torque_ctrl servo_velocity_torque_ctrl_i (.ref_clk(ref_clk), .rst(rst),
		.ce(ce), .od(link), .fault_event(fault_event), .alarm_event(alarm_event),
		.alarm_clearable(alarm_clearable), .sw_limit_hit(sw_limit_hit),
		.measured_speed_in(measured_speed_in), .drive_enabled(drive_enabled),
		.velocity_run(velocity_run), .torque_run(torque_run), .speed_command(speed_command),
		.torque_reference(torque_reference), .status_word(status_word));
	servo_host_seq servo_host_seq_i (.ref_clk(ref_clk), .rst(rst), .ce(ce), .od(link),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind),
		.cmd_index(cmd_index), .cmd_data(cmd_data), .resp_valid(resp_valid),
		.resp_data(resp_data), .resp_miss(resp_miss));
	servo_vt_asserts servo_vt_asserts_i (.ref_clk(ref_clk), .rst(rst), .req(link.req),
		.we(link.we), .index(link.index), .wdata(link.wdata), .ack(link.ack),
		.rdata(link.rdata), .miss(link.miss));
	// ****************************************
	// Tasks
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// Waits n edges, then steps off the edge
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc
	// One user command, with a bounded wait for ready and for the answer
	task automatic cmd(input logic [2:0] k, input logic [15:0] i, input logic [31:0] d);
		int n;
		n = 0;
		cmd_kind = k;
		cmd_index = i;
		cmd_data = d;
		while (cmd_ready !== 1'b1 && n < 50) begin
			cyc(1);
			n++;
		end
		cmd_valid = 1;
		cyc(1);
		cmd_valid = 0;
		while (resp_valid !== 1'b1 && n < 100) begin
			cyc(1);
			n++;
		end
		// A lost answer counts as a mismatch
		if (resp_valid !== 1'b1) bad_count++;
		got = resp_data;
	endtask : cmd
	task automatic rdc(input logic [15:0] i, input logic [31:0] e);
		cmd(CMD_READ, i, 0);
		check(got, e);
	endtask : rdc
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : summarize
	// ****************************************
	// Tests
	// ****************************************
	// Watchdog: the sequence needs a few thousand cycles at most
	initial begin
		#100000;
		bad_count++;
		summarize();
	end
	initial begin
		cyc(6);
		rst = 0;
		for (int k = 0; k < 8; k++) rdc(ri[k], rv[k]);
		cmd(CMD_READ, 16'h1234, 0);
		check(resp_miss, 1);
		$display("reset test done");
		cmd(CMD_TORQUE_MODE, 0, 0);
		rdc(IDX_MODE_READBACK, 4);
		cmd(CMD_WRITE, IDX_TARGET_TORQUE, 100);
		cmd(CMD_WRITE, IDX_TORQUE_SLOPE, 10);
		cmd(CMD_ENABLE, 0, 0);
		cyc(20);
		rdc(IDX_TORQUE_REFERENCE, 100);
		rdc(IDX_STATUS_WORD, 32'h637);
		check(torque_run, 1);
		cmd(CMD_WRITE, IDX_TARGET_TORQUE, 200);
		got = torque_reference;
		cyc(3);
		check(torque_reference - got[15:0], 30);
		check(status_word[10], 0);
		cyc(15);
		cmd(CMD_WRITE, IDX_CONTROL_WORD, 32'hfe7f);
		cyc(3);
		check({drive_enabled, torque_reference}, {1'b1, 16'd200});
		cmd(CMD_WRITE, IDX_CONTROL_WORD, 32'h10f);
		cyc(25);
		check(torque_reference, 0);
		cmd(CMD_WRITE, IDX_CONTROL_WORD, 32'hf);
		cyc(25);
		check(torque_reference, 200);
		cmd(CMD_WRITE, IDX_CONTROL_WORD, 32'hb);
		cyc(30);
		check({torque_reference, status_word[6], status_word[2]}, 18'h2);
		$display("torque test done");
		cmd(CMD_VELOCITY_MODE, 0, 0);
		cmd(CMD_WRITE, IDX_TARGET_SPEED, 32'h140000);
		cmd(CMD_ENABLE, 0, 0);
		cyc(3);
		check({velocity_run, speed_command}, {1'b1, 32'h140000});
		rdc(IDX_MODE_READBACK, 3);
		rdc(IDX_MEASURED_SPEED, 32'h12345678);
		cmd(CMD_WRITE, IDX_CONTROL_WORD, 32'h10f);
		cyc(3);
		check(speed_command, 0);
		cmd(CMD_WRITE, IDX_CONTROL_WORD, 32'h7);
		cyc(3);
		check(drive_enabled, 0);
		$display("velocity test done");
		fault_event = 1;
		cyc(1);
		fault_event = 0;
		cyc(3);
		check({status_word[7], status_word[6], status_word[3]}, 3'b111);
		cmd(CMD_CLEAR_ALARM, 0, 0);
		cyc(3);
		check(status_word[3], 1);
		alarm_clearable = 1;
		cmd(CMD_WRITE, IDX_CONTROL_WORD, 32'h80);
		cyc(3);
		check(status_word[3], 1);
		cmd(CMD_CLEAR_ALARM, 0, 0);
		cyc(3);
		check({status_word[7], status_word[3]}, 0);
		cmd(CMD_WRITE, IDX_CONTROL_WORD, 32'h86);
		cyc(3);
		check(status_word[0], 0);
		cmd(CMD_WRITE, IDX_CONTROL_WORD, 32'h6);
		cyc(3);
		check(status_word[0], 1);
		rdc(IDX_CONTROL_WORD, 32'h6);
		alarm_event = 1;
		cyc(1);
		alarm_event = 0;
		cyc(3);
		check({status_word[7], status_word[3]}, 2'b10);
		cmd(CMD_CLEAR_ALARM, 0, 0);
		cyc(3);
		check(status_word[7], 0);
		ce = 0;
		sw_limit_hit = 1;
		cyc(3);
		check(status_word[11], 0);
		ce = 1;
		cyc(3);
		check(status_word[11], 1);
		sw_limit_hit = 0;
		cyc(3);
		check(status_word[11], 0);
		$display("fault test done");
		summarize();
	end
endmodule : test_servo_velocity_torque_ctrl
